// File: hdl/mcirq_top.sv
// interrupt flags, mask and clear of the media card host interface
// assumes queue state is synchronous to sys_clk, card interrupt is a pin
// Contract
// - raw bit 5 on receive queue full
// - raw bit 4 when rx level exceeds threshold
// - raw bit 3 when rx leaves empty
// - raw bit 2 when tx leaves full
// - raw bit 1 when tx space exceeds threshold
// - raw bit 0 on transmit queue empty
// - per-source mask register at 0x04
// - mask one suppresses, zero lets through
// - mask resets 0x7ffff, bits 31-19 reserved
// - write-only clear register at 0x08
// - writing one clears flags 17..0
// - sdio flag not clearable, follows card
`timescale 1ns/1ps
module mcirq_top
    import mcirq_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // queue state from the fifo datapath
    input  wire mcirq_queue_s      queue,
    // events from other parts of the interface, one-cycle pulses
    input  wire logic [17:6]       other_events,
    // card interrupt pin, active high
    input  wire logic              card_irq,
    // interrupt output
    output logic                   irq
);
    logic [18:0]        raw_q;
    logic [18:0]        raw_d;
    logic [18:0]        mask_q;
    logic [18:0]        mask_d;
    logic [LEVEL_W-1:0] rx_thr_q;
    logic [LEVEL_W-1:0] rx_thr_d;
    logic [LEVEL_W-1:0] tx_thr_q;
    logic [LEVEL_W-1:0] tx_thr_d;
    logic [31:0]        rdata_q;
    logic               ack_q;
    logic [5:0]         cond;
    logic [5:0]         rise;
    logic               card_irq_s;
    logic [18:0]        set_vec;
    logic [18:0]        clr_vec;
    mcirq_bus_s         req;

    // one wait cycle per access keeps read data registered
    assign req = '{rd: avs_read, wr: avs_write, addr: avs_address, wdata: avs_writedata};
    assign avs_waitrequest = (req.rd | req.wr) & ~ack_q;
    wire   take    = (req.rd | req.wr) & ~ack_q;
    wire   wr_take = take & req.wr;
    wire   rd_take = take & req.rd;

    // address decode
    wire hit_mask  = req.addr == OFF_MASK;
    wire hit_clear = req.addr == OFF_CLEAR;
    wire hit_level = req.addr == OFF_LEVEL;
    wire hit_stat  = req.addr == OFF_STATUS;

    // byte-enable merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // threshold comparison, shared by both directions
    function automatic logic above(input logic [LEVEL_W-1:0] v, input logic [LEVEL_W-1:0] t);
        return v > t;
    endfunction : above

    // level conditions whose rising edges raise the flags
    assign cond[BIT_TX_EMPTY]    = queue.tx_empty;
    assign cond[BIT_TX_SPACE]    = above(queue.tx_space, tx_thr_q);
    assign cond[BIT_TX_NOTFULL]  = ~queue.tx_full;
    assign cond[BIT_RX_NONEMPTY] = ~queue.rx_empty;
    assign cond[BIT_RX_LEVEL]    = above(queue.rx_level, rx_thr_q);
    assign cond[BIT_RX_FULL]     = queue.rx_full;

    mcirq_edge #(
        .W (6)
    ) u_edge (
        .sys_clk (sys_clk),
        .reset   (reset),
        .cond    (cond),
        .rise    (rise)
    );

    mcirq_sync u_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .din     (card_irq),
        .dout    (card_irq_s)
    );

    // clear vector: only ones in bits 17..0, reserved bits ignored
    wire [31:0] clr_word = merge(32'h0000_0000, req.wdata, avs_byteenable);
    assign clr_vec = (wr_take & hit_clear) ?
                     {1'b0, clr_word[CLR_COUNT-1:0]} : 19'h00000;
    assign set_vec = {1'b0, other_events, rise};

    // set wins over clear; sdio bit mirrors the card line
    always_comb begin
        raw_d = (raw_q & ~clr_vec) | set_vec;
        raw_d[BIT_SDIO] = card_irq_s;
    end

    // mask and threshold writes
    wire [31:0] mask_word = merge({13'h0000, mask_q}, req.wdata, avs_byteenable);
    wire [31:0] lvl_word  = merge({16'h0000, tx_thr_q, rx_thr_q}, req.wdata, avs_byteenable);
    assign mask_d   = (wr_take & hit_mask) ? mask_word[SRC_COUNT-1:0] : mask_q;
    assign rx_thr_d = (wr_take & hit_level) ? lvl_word[7:0] : rx_thr_q;
    assign tx_thr_d = (wr_take & hit_level) ? lvl_word[15:8] : tx_thr_q;

    // read mux; clear reads zero, unmapped reads zero
    wire [31:0] rd_mux = hit_stat  ? {13'h0000, raw_q} :
                         hit_mask  ? {13'h0000, mask_q} :
                         hit_level ? {16'h0000, tx_thr_q, rx_thr_q} :
                                     32'h0000_0000;

    // state registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            raw_q    <= STATUS_RESET;
            mask_q   <= MASK_RESET;
            rx_thr_q <= LEVEL_RESET;
            tx_thr_q <= LEVEL_RESET;
        end else begin
            raw_q    <= raw_d;
            mask_q   <= mask_d;
            rx_thr_q <= rx_thr_d;
            tx_thr_q <= tx_thr_d;
        end
    end

    // bus answer registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= take;
            rdata_q <= rd_take ? rd_mux : rdata_q;
        end
    end

    assign avs_readdata = rdata_q;

    // raw flags stay readable; mask gates only the output
    assign irq = |(raw_q & ~mask_q);
endmodule : mcirq_top

// File: hdl/mcirq_pkg.sv
// package for the media card interrupt bookkeeping block
// assumes a 32-bit avalon-mm register slave on sys_clk
package mcirq_pkg;

    localparam int unsigned SRC_COUNT     = 19;
    localparam int unsigned CLR_COUNT     = 18;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned LEVEL_W       = 8;

    // byte offsets of the words
    localparam logic [3:0]  OFF_STATUS    = 4'h0;
    localparam logic [3:0]  OFF_MASK      = 4'h4;
    localparam logic [3:0]  OFF_CLEAR     = 4'h8;
    localparam logic [3:0]  OFF_LEVEL     = 4'hc;

    // bit positions of the raw flags
    localparam int unsigned BIT_TX_EMPTY   = 0;
    localparam int unsigned BIT_TX_SPACE   = 1;
    localparam int unsigned BIT_TX_NOTFULL = 2;
    localparam int unsigned BIT_RX_NONEMPTY = 3;
    localparam int unsigned BIT_RX_LEVEL   = 4;
    localparam int unsigned BIT_RX_FULL    = 5;
    localparam int unsigned BIT_SDIO       = 18;

    // reset values
    localparam logic [18:0] MASK_RESET    = 19'h7ffff;
    localparam logic [18:0] STATUS_RESET  = 19'h00000;
    localparam logic [7:0]  LEVEL_RESET   = 8'h00;

    // queue state as seen by the detectors
    typedef struct packed {
        logic             rx_full;
        logic             rx_empty;
        logic [LEVEL_W-1:0] rx_level;
        logic             tx_full;
        logic             tx_empty;
        logic [LEVEL_W-1:0] tx_space;
    } mcirq_queue_s;

    // register bus request
    typedef struct packed {
        logic             rd;
        logic             wr;
        logic [ADDR_W-1:0] addr;
        logic [31:0]      wdata;
    } mcirq_bus_s;

endpackage : mcirq_pkg

// File: hdl/mcirq_edge.sv
// rising-edge detector bank for the queue conditions
// assumes all conditions are on sys_clk already
`timescale 1ns/1ps
module mcirq_edge
    import mcirq_pkg::*;
#(
    parameter int unsigned W = 6
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // conditions and their rising edges
    input  wire logic [W-1:0] cond,
    output logic [W-1:0]      rise
);
    logic [W-1:0] prev_q;

    // previous value; reset to all ones so no spurious edge at release
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev_q <= '1;
        end else begin
            prev_q <= cond;
        end
    end

    assign rise = cond & ~prev_q;
endmodule : mcirq_edge

// File: hdl/mcirq_sync.sv
// two flip-flop synchroniser for the card interrupt line
// assumes the input comes from the card pin domain
`timescale 1ns/1ps
module mcirq_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // async in, synced out
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    logic sync_q;

    // first stage is read only by the second
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule : mcirq_sync

// File: dv/mcirq_card.sv
// card model driving the interrupt pin
// assumes the bench says when the card wants service
`timescale 1ns/1ps
module mcirq_card (
    // clock and command
    input  wire logic sys_clk,
    input  wire logic want,
    // card interrupt pin
    output logic      card_irq
);
    // only the card itself withdraws the line
    always_ff @(posedge sys_clk) begin
        card_irq <= want;
    end
endmodule : mcirq_card

// File: dv/mcirq_chk.sv
// assertions on the ports of the interrupt bookkeeping top
// assumes the bind below
`timescale 1ns/1ps
module mcirq_chk
    import mcirq_pkg::*;
(
    // watched ports
    input wire logic              sys_clk,
    input wire logic              reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire mcirq_queue_s      queue,
    input wire logic              card_irq,
    input wire logic              irq
);
    logic [18:0] mask_q;
    wire         rd_ok = avs_read && !avs_waitrequest;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // mask shadow, updated at the taking edge (full lanes only)
    always_ff @(posedge sys_clk) begin
        if (reset) mask_q <= MASK_RESET;
        else if (avs_write && avs_waitrequest && avs_address == OFF_MASK)
            mask_q <= avs_writedata[18:0];
    end
    sequence taken_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    one_wait_a: assert property (taken_s |=> !avs_waitrequest) else $error("no answer");
    clr_zero_a: assert property (rd_ok && avs_address == OFF_CLEAR |-> avs_readdata == 0)
        else $error("clear read not zero");
    mask_read_a: assert property (rd_ok && avs_address == OFF_MASK |->
        avs_readdata == {13'h0, mask_q}) else $error("mask readback");
    all_mask_a: assert property (&mask_q |-> !irq) else $error("masked irq");
    rx_full_a: assert property (!$past(reset) && $rose(queue.rx_full) && !mask_q[5] |=> irq)
        else $error("rx full lost");
    rx_ne_a: assert property (!$past(reset) && $fell(queue.rx_empty) && !mask_q[3] |=> irq)
        else $error("rx nonempty lost");
    tx_nf_a: assert property (!$past(reset) && $fell(queue.tx_full) && !mask_q[2] |=> irq)
        else $error("tx notfull lost");
    tx_empty_a: assert property (!$past(reset) && $rose(queue.tx_empty) && !mask_q[0] |=> irq)
        else $error("tx empty lost");
    card_irq_a: assert property (card_irq [*5] ##0 !mask_q[18] |-> irq)
        else $error("card irq lost");
endmodule : mcirq_chk
bind mcirq_top mcirq_chk CHK (.*);

// File: dv/tb_media_card_irq_mask_clear.sv
// self-checking bench for the interrupt bookkeeping block
// assumes the card model and a four-bit byte address bus
`timescale 1ns/1ps
module tb_media_card_irq_mask_clear
    import mcirq_pkg::*;
;
    logic              sys_clk = 0, reset = 1, avs_read = 0, avs_write = 0, want = 0;
    logic [ADDR_W-1:0] avs_address = 0;
    logic [31:0]       avs_writedata = 0, rdata, avs_readdata;
    logic [3:0]        avs_byteenable = 4'hf;
    logic              avs_waitrequest, card_irq, irq;
    logic [17:6]       other_events = 0;
    mcirq_queue_s      queue = '{0, 1, 0, 1, 0, 0};
    int                bad_count = 0, check_count = 0;
    mcirq_top DUT (.*);
    mcirq_card CARD (.sys_clk, .want, .card_irq);
    // 50 ns clock
    always #25 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // one bus access, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_write     <= w;
        avs_read      <= !w;
        avs_address   <= a;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            bad_count++;
            end_of_test();
        end
        rdata = avs_readdata;
        avs_write <= 0;
        avs_read  <= 0;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(0, a, 0);
        chk(rdata, exp);
    endtask : rd
    // bounded wait for the interrupt level, then judge it
    task automatic wirq(input logic exp);
        for (int n = 0; n < 10 && irq !== exp; n++) @(negedge sys_clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : wirq
    task automatic t_queue;
        rd(OFF_MASK, 32'h7ffff);
        rd(OFF_STATUS, 0);
        bus(1, OFF_MASK, 32'hfff7ffc0);
        queue <= '{1, 0, 8'hff, 0, 1, 8'hff};
        wirq(1);
        rd(OFF_STATUS, 32'h3f);
        bus(1, OFF_MASK, 32'hffffffff);
        wirq(0);
        bus(1, OFF_CLEAR, 32'hfff80015);
        rd(OFF_STATUS, 32'h2a);
        bus(1, OFF_MASK, 32'h7fffd);
        rd(OFF_MASK, 32'h7fffd);
        wirq(1);
        bus(1, OFF_CLEAR, 32'h2a);
        wirq(0);
        rd(OFF_CLEAR, 0);
        rd(4'h1, 0);
    endtask : t_queue
    task automatic t_other;
        other_events <= 12'hfff;
        @(posedge sys_clk);
        other_events <= 0;
        repeat (2) @(posedge sys_clk);
        rd(OFF_STATUS, 32'h3ffc0);
        bus(1, OFF_CLEAR, 32'h3ffc0);
        rd(OFF_STATUS, 0);
    endtask : t_other
    task automatic t_card;
        bus(1, OFF_MASK, 32'h3ffff);
        want <= 1;
        wirq(1);
        bus(1, OFF_CLEAR, 32'h40000);
        rd(OFF_STATUS, 32'h40000);
        want <= 0;
        wirq(0);
    endtask : t_card
    // watchdog: a hang is a mismatch
    initial begin
        #1000000;
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 0;
        t_queue();
        t_other();
        t_card();
        end_of_test();
    end
endmodule : tb_media_card_irq_mask_clear
